// ===== rtl/e1_rx_event_pkg.sv
package e1_rx_event_pkg;

   // Register indices; the Avalon byte address is four times the index
   localparam logic [9:0] IDX_MODE        = 10'h04E;
   localparam logic [9:0] IDX_STATUS      = 10'h04F;
   localparam logic [9:0] IDX_IRQ_EN      = 10'h051;
   localparam logic [9:0] IDX_SYNC_EVENTS = 10'h052;
   localparam logic [9:0] IDX_ERR_EVENTS  = 10'h053;
   localparam logic [9:0] IDX_TS0_CAPTURE = 10'h054;
   localparam logic [9:0] IDX_TS16_SPARE  = 10'h055;
   localparam logic [9:0] IDX_ERR_COUNT   = 10'h060;

   // Mode register fields
   localparam int unsigned MODE_PATTERN_BIT = 3;
   localparam int unsigned MODE_NFAS_BIT    = 4;

   // Interrupt enable fields
   localparam int unsigned EN_ALIGN_BIT     = 0;
   localparam int unsigned EN_FRAME_ERR_BIT = 1;

   // Sync event register fields
   localparam int unsigned SEV_EXCESS_CRC_BIT = 5;

   // Error event register fields
   localparam int unsigned EEV_ALIGN_CHANGE = 0;
   localparam int unsigned EEV_FRAME_ERR    = 1;
   localparam int unsigned EEV_CRC4_ERR     = 2;
   localparam int unsigned EEV_CRC_ALIGN    = 3;
   localparam int unsigned EEV_CRC_MF_START = 4;
   localparam int unsigned EEV_CAS_ALIGN    = 5;
   localparam int unsigned EEV_CRC_SMF      = 6;
   localparam int unsigned EEV_CAS_MF_START = 7;

   // Reset values
   localparam logic [4:0] STATUS_RST      = 5'h0D;
   localparam logic [7:0] EVENTS_RST      = 8'h00;
   localparam logic [7:0] TS0_CAPTURE_RST = 8'h00;
   localparam logic [2:0] TS16_SPARE_RST  = 3'h0;

   // Line patterns
   localparam logic [6:0] FAS_PATTERN     = 7'h1B;
   localparam logic [5:0] CRC_MF_PATTERN  = 6'h0B;
   localparam logic [3:0] CAS_MF_PATTERN  = 4'h0;
   localparam logic [4:0] TS_OVERHEAD     = 5'h00;
   localparam logic [4:0] TS_SIGNALLING   = 5'h10;
   localparam logic [3:0] CRC_SMF2_FRAME  = 4'h8;
   localparam logic [3:0] CRC_LAST_MFA_FR = 4'hB;

   // Excessive CRC-4 supervision
   localparam logic [9:0]  EXCESS_CRC_LIMIT = 10'h393;
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned WINDOW_TIME_MS   = 1000;
   localparam int unsigned WINDOW_CYCLES_DEF = (CLK_HZ / 1000) * WINDOW_TIME_MS;

endpackage

// ===== rtl/crc4_if.sv
`timescale 1ns/1ns
interface crc4_if;
   logic bit_valid;
   logic data_bit;
   logic smf_start;
   logic c_slot;
   logic check_en;
   logic err;

   modport framer  (output bit_valid, output data_bit, output smf_start, output c_slot, output check_en, input err);
   modport calc    (input bit_valid, input data_bit, input smf_start, input c_slot, input check_en, output err);
endinterface

// ===== rtl/crc4_checker.sv
`timescale 1ns/1ns
module crc4_checker import e1_rx_event_pkg::*; (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   crc4_if.calc      link
);

   typedef struct packed {
      logic [3:0] rem;
      logic [3:0] calc;
      logic [3:0] rx_c;
      logic       calc_valid;
      logic       err;
   } crc_s;

   crc_s crc_ff;
   crc_s nxt_crc;

   always_comb begin
      logic       fb;
      logic [3:0] rem_in;
      fb      = 1'b0;
      rem_in  = crc_ff.rem;
      nxt_crc = crc_ff;
      nxt_crc.err = 1'b0;
      if (link.bit_valid) begin
         if (link.smf_start) begin
            // C bits of this sub-multiframe belong to the previous one's remainder
            nxt_crc.err        = link.check_en && crc_ff.calc_valid && (crc_ff.rx_c != crc_ff.calc);
            nxt_crc.calc       = crc_ff.rem;
            nxt_crc.calc_valid = link.check_en;
            nxt_crc.rx_c       = 4'h0;
            rem_in             = 4'h0;
         end
         // C-bit slots enter the division as zero
         fb          = (link.data_bit & ~link.c_slot) ^ rem_in[3];
         nxt_crc.rem = {rem_in[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
         if (link.c_slot) begin
            nxt_crc.rx_c = {(link.smf_start ? 3'h0 : crc_ff.rx_c[2:0]), link.data_bit};
         end
      end
      if (!link.check_en) begin
         nxt_crc.calc_valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         crc_ff <= '0;
      end else begin
         crc_ff <= nxt_crc;
      end
   end

   assign link.err = crc_ff.err;

endmodule

// ===== rtl/e1_rx_framer_event_report.sv
// Functional notes
// - Frame error flag drives interrupt when enabled.
// - Alignment change flag drives interrupt when enabled.
// - Flag 915 or more CRC errors per second.
// - Excessive CRC supervision clears its count without CRC sync.
// - Any toggle of five status bits sets flags.
// - Writing one clears a flag; zero keeps it.
// - CAS multiframe start flag only while synced.
// - CRC sub-multiframe start flag only while synced.
// - CRC multiframe start flag only while synced.
// - CAS alignment bits not 0000 raise error.
// - CRC alignment bits not 001011 raise error.
// - Mismatched CRC-4 over sub-multiframe raises error.
// - FAS/NFAS error events only while frame synced.
// - Changed frame alignment position sets flag.
// - NFAS international bit captured into bit 7.
// - FAS international bit captured into bit 6.
// - NFAS remote alarm bit captured into bit 5.
// - NFAS national bits captured into bits 4..0.
// - Extra bits captured at next CAS start.
// - Remote multiframe alarm captured at CAS start.
// - Mode bits choose bit, pattern or NFAS errors.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module e1_rx_framer_event_report import e1_rx_event_pkg::*; #(
   parameter int unsigned WINDOW_CYCLES = WINDOW_CYCLES_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit,
   input  wire logic [4:0]  rx_timeslot,
   input  wire logic [2:0]  rx_bit_index,
   input  wire logic        rx_fas_frame,
   input  wire logic [3:0]  rx_crc_frame,
   input  wire logic [3:0]  rx_cas_frame,
   input  wire logic        rx_align_moved,
   input  wire logic        interwork_state,
   input  wire logic        cas_mf_out_of_sync,
   input  wire logic        crc_mf_out_of_sync,
   input  wire logic        offline_frame_out_of_sync,
   input  wire logic        frame_out_of_sync,
   output logic             frame_irq
);

   localparam int unsigned WIN_W = $clog2(WINDOW_CYCLES);

   typedef struct packed {
      logic             waitreq;
      logic [31:0]      rdata;
      logic             irq;
      logic             pattern_error_select;
      logic             count_nfas_select;
      logic             frame_err_irq_en;
      logic             align_change_irq_en;
      logic [4:0]       status_prev;
      logic [5:0]       sync_ev;
      logic [7:0]       err_ev;
      logic [7:0]       ts0_cap;
      logic [2:0]       ts16_cap;
      logic [2:0]       ts16_shadow;
      logic [6:0]       ts0_sh;
      logic [4:0]       mfa_sh;
      logic [2:0]       cas_sh;
      logic [WIN_W-1:0] win_cnt;
      logic [9:0]       crc_err_cnt;
      logic [7:0]       frame_err_cnt;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   crc4_if crc_bus ();

   crc4_checker u_crc4 (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .link    (crc_bus)
   );

   // Positions inside the frame and multiframe
   logic ts0_bit;
   logic ts16_bit;
   logic ts0_first;
   logic ts0_last;
   logic crc_mf_first;
   logic cas_mf_first;
   logic [4:0] status_now;

   assign ts0_bit      = rx_bit_valid && (rx_timeslot == TS_OVERHEAD);
   assign ts16_bit     = rx_bit_valid && (rx_timeslot == TS_SIGNALLING);
   assign ts0_first    = ts0_bit && (rx_bit_index == 3'h0);
   assign ts0_last     = ts0_bit && (rx_bit_index == 3'h7);
   assign crc_mf_first = ts0_first && rx_fas_frame && (rx_crc_frame == 4'h0);
   assign cas_mf_first = ts0_first && (rx_cas_frame == 4'h0);
   assign status_now   = {interwork_state, cas_mf_out_of_sync, crc_mf_out_of_sync,
                          offline_frame_out_of_sync, frame_out_of_sync};

   assign crc_bus.bit_valid = rx_bit_valid;
   assign crc_bus.data_bit  = rx_bit;
   assign crc_bus.smf_start = ts0_first && rx_fas_frame &&
                              ((rx_crc_frame == 4'h0) || (rx_crc_frame == CRC_SMF2_FRAME));
   assign crc_bus.c_slot    = ts0_first && rx_fas_frame;
   assign crc_bus.check_en  = !crc_mf_out_of_sync;

   function automatic logic [3:0] ones7(input logic [6:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 7; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   always_comb begin
      logic       req;
      logic       take_wr;
      logic [9:0] idx;
      logic [7:0] wbyte;
      logic [7:0] ts0_byte;
      logic [6:0] fas_diff;
      logic       fas_bad;
      logic       nfas_bad;
      logic       frame_ev;
      logic [3:0] frame_ev_n;
      logic [8:0] frame_sum;
      logic [7:0] err_set;
      logic [5:0] sync_set;
      logic       win_end;
      logic [7:0] rd;

      nxt_st     = st_ff;
      req        = avs_read || avs_write;
      idx        = avs_address[11:2];
      take_wr    = avs_write && !st_ff.waitreq && avs_byteenable[0];
      wbyte      = avs_writedata[7:0];
      ts0_byte   = {st_ff.ts0_sh, rx_bit};
      fas_diff   = ts0_byte[6:0] ^ FAS_PATTERN;
      fas_bad    = |fas_diff;
      nfas_bad   = !ts0_byte[6];
      frame_ev   = 1'b0;
      frame_ev_n = 4'h0;
      frame_sum  = 9'h000;
      err_set    = 8'h00;
      sync_set   = 6'h00;
      win_end    = (st_ff.win_cnt == WIN_W'(WINDOW_CYCLES - 1));
      rd         = 8'h00;

      // Bit collection per slot
      if (ts0_bit) begin
         nxt_st.ts0_sh = {st_ff.ts0_sh[5:0], rx_bit};
      end
      if (ts0_first && !rx_fas_frame && rx_crc_frame[0] && (rx_crc_frame <= CRC_LAST_MFA_FR)) begin
         nxt_st.mfa_sh = {st_ff.mfa_sh[3:0], rx_bit};
      end
      if (ts16_bit && (rx_cas_frame == 4'h0)) begin
         if (rx_bit_index < 3'h3) begin
            nxt_st.cas_sh = {st_ff.cas_sh[1:0], rx_bit};
         end
         if (rx_bit_index == 3'h3) begin
            err_set[EEV_CAS_ALIGN] = !cas_mf_out_of_sync && ({st_ff.cas_sh, rx_bit} != CAS_MF_PATTERN);
         end
         if (rx_bit_index == 3'h5) begin
            nxt_st.ts16_shadow[2] = rx_bit;
         end
         if (rx_bit_index == 3'h6) begin
            nxt_st.ts16_shadow[1] = rx_bit;
         end
         if (rx_bit_index == 3'h7) begin
            nxt_st.ts16_shadow[0] = rx_bit;
         end
      end

      // Overhead capture and basic frame error events
      if (ts0_last && !frame_out_of_sync) begin
         if (rx_fas_frame) begin
            nxt_st.ts0_cap[6] = ts0_byte[7];
            frame_ev   = fas_bad;
            frame_ev_n = st_ff.pattern_error_select ? {3'h0, fas_bad} : ones7(fas_diff);
         end else begin
            nxt_st.ts0_cap[7]   = ts0_byte[7];
            nxt_st.ts0_cap[5]   = ts0_byte[5];
            nxt_st.ts0_cap[4:0] = ts0_byte[4:0];
            frame_ev   = st_ff.count_nfas_select && nfas_bad;
            frame_ev_n = {3'h0, frame_ev};
         end
      end
      err_set[EEV_FRAME_ERR] = frame_ev;
      frame_sum = {1'b0, st_ff.frame_err_cnt} + {5'h00, frame_ev_n};
      nxt_st.frame_err_cnt = frame_sum[8] ? 8'hFF : frame_sum[7:0];

      // Multiframe markers and alignment checks
      if (ts0_first && !crc_mf_out_of_sync) begin
         err_set[EEV_CRC_MF_START] = crc_mf_first;
         err_set[EEV_CRC_SMF]      = crc_bus.smf_start;
         err_set[EEV_CRC_ALIGN]    = !rx_fas_frame && (rx_crc_frame == CRC_LAST_MFA_FR) &&
                                     ({st_ff.mfa_sh, rx_bit} != CRC_MF_PATTERN);
      end
      if (cas_mf_first && !cas_mf_out_of_sync) begin
         err_set[EEV_CAS_MF_START] = 1'b1;
         nxt_st.ts16_cap = st_ff.ts16_shadow;
      end
      err_set[EEV_CRC4_ERR]     = crc_bus.err;
      err_set[EEV_ALIGN_CHANGE] = rx_align_moved;

      // Fixed one-second windows for excessive CRC-4 errors
      nxt_st.win_cnt = win_end ? '0 : st_ff.win_cnt + WIN_W'(1);
      if (crc_mf_out_of_sync || win_end) begin
         nxt_st.crc_err_cnt = 10'h000;
      end else if (crc_bus.err && (st_ff.crc_err_cnt != 10'h3FF)) begin
         nxt_st.crc_err_cnt = st_ff.crc_err_cnt + 10'h001;
      end
      sync_set[SEV_EXCESS_CRC_BIT] = !crc_mf_out_of_sync && !win_end && crc_bus.err &&
                                     (st_ff.crc_err_cnt == EXCESS_CRC_LIMIT - 10'h001);
      sync_set[4:0] = status_now ^ st_ff.status_prev;
      nxt_st.status_prev = status_now;

      // Set beats a clear arriving in the same cycle
      nxt_st.sync_ev = st_ff.sync_ev & ~((take_wr && idx == IDX_SYNC_EVENTS) ? wbyte[5:0] : 6'h00);
      nxt_st.sync_ev = nxt_st.sync_ev | sync_set;
      nxt_st.err_ev  = st_ff.err_ev & ~((take_wr && idx == IDX_ERR_EVENTS) ? wbyte : 8'h00);
      nxt_st.err_ev  = nxt_st.err_ev | err_set;

      if (take_wr && idx == IDX_MODE) begin
         nxt_st.pattern_error_select = wbyte[MODE_PATTERN_BIT];
         nxt_st.count_nfas_select    = wbyte[MODE_NFAS_BIT];
      end
      if (take_wr && idx == IDX_IRQ_EN) begin
         nxt_st.frame_err_irq_en    = wbyte[EN_FRAME_ERR_BIT];
         nxt_st.align_change_irq_en = wbyte[EN_ALIGN_BIT];
      end
      if (take_wr && idx == IDX_ERR_COUNT) begin
         nxt_st.frame_err_cnt = 8'h00;
      end

      nxt_st.irq = (nxt_st.err_ev[EEV_FRAME_ERR] && nxt_st.frame_err_irq_en) ||
                   (nxt_st.err_ev[EEV_ALIGN_CHANGE] && nxt_st.align_change_irq_en);

      // One wait cycle, then answer; unmapped reads return zero
      unique case (idx)
         IDX_MODE: begin
            rd[MODE_PATTERN_BIT] = st_ff.pattern_error_select;
            rd[MODE_NFAS_BIT]    = st_ff.count_nfas_select;
         end
         IDX_STATUS:      rd = {3'h0, status_now};
         IDX_IRQ_EN: begin
            rd[EN_FRAME_ERR_BIT] = st_ff.frame_err_irq_en;
            rd[EN_ALIGN_BIT]     = st_ff.align_change_irq_en;
         end
         IDX_SYNC_EVENTS: rd = {2'h0, st_ff.sync_ev};
         IDX_ERR_EVENTS:  rd = st_ff.err_ev;
         IDX_TS0_CAPTURE: rd = st_ff.ts0_cap;
         IDX_TS16_SPARE:  rd = {5'h00, st_ff.ts16_cap};
         IDX_ERR_COUNT:   rd = st_ff.frame_err_cnt;
         default:         rd = 8'h00;
      endcase
      nxt_st.waitreq = !(req && st_ff.waitreq);
      if (avs_read && st_ff.waitreq) begin
         nxt_st.rdata = {24'h000000, rd};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_ff             <= '0;
         st_ff.waitreq     <= 1'b1;
         st_ff.status_prev <= STATUS_RST;
         st_ff.sync_ev     <= EVENTS_RST[5:0];
         st_ff.err_ev      <= EVENTS_RST;
         st_ff.ts0_cap     <= TS0_CAPTURE_RST;
         st_ff.ts16_cap    <= TS16_SPARE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata    = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitreq;
   assign frame_irq       = st_ff.irq;

endmodule

// ===== verification/e1_line_model.sv
`timescale 1ns/1ns
module e1_line_model import e1_rx_event_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [4:0] inj,
   input  wire logic [7:0] ovh,
   output logic            rx_bit_valid,
   output logic            rx_bit,
   output logic [4:0]      rx_timeslot,
   output logic [2:0]      rx_bit_index,
   output logic            rx_fas_frame,
   output logic [3:0]      rx_crc_frame,
   output logic [3:0]      rx_cas_frame
);
   // One bit per clock; payload is random so the remainder is never trivially zero
   logic [11:0] cnt_ff;
   logic [3:0]  crc_ff, crc_prev_ff, c_src, base;
   logic        rnd_ff, smf, c_slot, b_eff;
   assign {rx_crc_frame, rx_timeslot, rx_bit_index} = cnt_ff;
   assign rx_cas_frame = rx_crc_frame;
   assign rx_fas_frame = ~cnt_ff[8];
   assign smf = cnt_ff[10:0] == 11'h000;
   assign c_slot = rx_fas_frame && cnt_ff[7:0] == 8'h00;
   assign c_src = smf ? crc_ff : crc_prev_ff;
   assign base = smf ? 4'h0 : crc_ff;
   assign b_eff = c_slot ? 1'b0 : rx_bit;
   always_comb begin
      rx_bit = rnd_ff;
      if (rx_timeslot == TS_OVERHEAD) begin
         if (c_slot)
            rx_bit = c_src[2'd3 - rx_crc_frame[2:1]] ^ inj[2];
         else if (rx_fas_frame)
            rx_bit = FAS_PATTERN[3'd7 - rx_bit_index] ^ (inj[0] && rx_bit_index > 3'd5);
         else if (rx_bit_index == 3'd0)
            rx_bit = (rx_crc_frame < 4'hC) ? CRC_MF_PATTERN[3'd5 - rx_crc_frame[3:1]] ^ inj[3] : ovh[7];
         else if (rx_bit_index == 3'd1)
            rx_bit = ~inj[1];
         else
            rx_bit = ovh[3'd7 - rx_bit_index];
      end else if (rx_timeslot == TS_SIGNALLING && rx_crc_frame == 4'h0) begin
         rx_bit = (rx_bit_index < 3'd4) ? inj[4] : ovh[3'd7 - rx_bit_index];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_ff <= 12'h000;
         crc_ff <= 4'h0;
         crc_prev_ff <= 4'h0;
         rx_bit_valid <= 1'b0;
         rnd_ff <= 1'b0;
      end else begin
         rx_bit_valid <= 1'b1;
         rnd_ff <= 1'($urandom);
         if (rx_bit_valid) begin
            cnt_ff <= cnt_ff + 12'h001;
            crc_ff <= {base[2:1], base[0] ^ base[3] ^ b_eff, base[3] ^ b_eff};
            if (smf)
               crc_prev_ff <= crc_ff;
         end
      end
   end
endmodule

// ===== verification/e1_rx_checker.sv
`timescale 1ns/1ns
module e1_rx_checker import e1_rx_event_pkg::*; (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        rx_bit_valid,
   input wire logic [4:0]  rx_timeslot,
   input wire logic [2:0]  rx_bit_index,
   input wire logic        rx_align_moved,
   input wire logic        frame_irq
);
   logic       acc, wr_en, wr_err, fas_slot;
   logic [1:0] en_ff;
   assign acc = (avs_read || avs_write) && !avs_waitrequest;
   assign wr_en = avs_write && avs_address[11:2] == IDX_IRQ_EN && avs_byteenable[0];
   assign wr_err = avs_write && avs_address[11:2] == IDX_ERR_EVENTS && avs_byteenable[0];
   assign fas_slot = rx_bit_valid && rx_timeslot == TS_OVERHEAD && rx_bit_index == 3'd7;
   // Shadow of the enables, so the interrupt can be judged without peeking inside
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         en_ff <= 2'b00;
      else if (wr_en && acc)
         en_ff <= avs_writedata[1:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("request not answered after one wait cycle");
   property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low for more than one cycle");
   property p_rd_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
   property p_rst_out; $fell(sys_rst) |-> avs_waitrequest && !frame_irq && avs_readdata == 32'h0; endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
   property p_irq_off; en_ff == 2'b00 && $past(en_ff) == 2'b00 |-> !frame_irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt with both enables off");
   property p_align_irq; rx_align_moved && en_ff[0] && !wr_en |=> frame_irq; endproperty
   a_align_irq: assert property (p_align_irq) else $error("alignment change gave no interrupt");
   property p_irq_hold; frame_irq && !wr_en && !wr_err && !$past(wr_en) |=> frame_irq; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a write");
   property p_irq_cause; $rose(frame_irq) |-> $past(rx_align_moved || fas_slot || wr_en); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without a cause");
   property p_irq_clr;
      acc && wr_err && avs_writedata[1:0] == 2'b11 && !rx_align_moved && !fas_slot && !$past(wr_en) |=> !frame_irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("interrupt stayed after clearing both flags");
   c_align: cover property (rx_align_moved && en_ff[0]);
   c_rise: cover property ($rose(frame_irq));
   c_clear: cover property (acc && wr_err);
endmodule

// ===== verification/e1_rx_framer_event_report_tb.sv
`timescale 1ns/1ns
module e1_rx_framer_event_report_tb import e1_rx_event_pkg::*;;
   typedef struct packed {logic [7:0] v; logic [7:0] m;} exp_s;
   typedef struct packed {logic [7:0] mode; logic [4:0] st; logic [4:0] inj; logic [7:0] e;} case_s;
   logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, frame_irq, rx_align_moved;
   logic        rx_bit_valid, rx_bit, rx_fas_frame;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, rx_crc_frame, rx_cas_frame;
   logic [4:0]  rx_timeslot, st, inj;
   logic [2:0]  rx_bit_index;
   logic [7:0]  ovh, o, md;
   int          failures, checks, n, k, nfe;
   exp_s        q[$];
   exp_s        ex;
   case_s       tbl [8];
   e1_rx_framer_event_report #(.WINDOW_CYCLES(2000)) dut (.sys_clk, .sys_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_bit_valid, .rx_bit,
      .rx_timeslot, .rx_bit_index, .rx_fas_frame, .rx_crc_frame, .rx_cas_frame, .rx_align_moved,
      .interwork_state(st[4]), .cas_mf_out_of_sync(st[3]), .crc_mf_out_of_sync(st[2]),
      .offline_frame_out_of_sync(st[1]), .frame_out_of_sync(st[0]), .frame_irq);
   e1_line_model line (.sys_clk, .sys_rst, .inj, .ovh, .rx_bit_valid, .rx_bit, .rx_timeslot, .rx_bit_index,
      .rx_fas_frame, .rx_crc_frame, .rx_cas_frame);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] be);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge sys_clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [7:0] m);
      q.push_back('{e, m});
      bus(1'b0, idx, 8'h00, 4'hF);
   endtask
   // Read answers are judged here against the oldest noted expectation
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         ex = (q.size() > 0) ? q.pop_front() : '{8'hXX, 8'hFF};
         chk(avs_readdata & {24'hFFFFFF, ex.m}, {24'h0, ex.v & ex.m});
      end
   end
   // Frame error count that the injected faults must produce
   always @(posedge sys_clk)
      if (rx_bit_valid && rx_timeslot == TS_OVERHEAD && rx_bit_index == 3'd7 && !st[0])
         nfe <= nfe + (rx_fas_frame ? (inj[0] ? (md[3] ? 1 : 2) : 0) : int'(inj[1] && md[4]));
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      stop_test();
   end
   initial begin
      void'($urandom(73));
      {sys_rst, avs_read, avs_write, rx_align_moved} = 4'h8;
      {avs_address, avs_writedata, avs_byteenable, inj} = '0;
      st = STATUS_RST;
      ovh = 8'($urandom);
      tbl = '{'{8'h00, 5'h00, 5'h01, 8'hD2}, '{8'h00, 5'h00, 5'h02, 8'hD0}, '{8'h08, 5'h00, 5'h01, 8'hD2},
              '{8'h08, 5'h00, 5'h02, 8'hD0}, '{8'h10, 5'h00, 5'h02, 8'hD2}, '{8'h18, 5'h00, 5'h02, 8'hD2},
              '{8'h00, 5'h00, 5'h1C, 8'hFC}, '{8'h00, 5'h0D, 5'h1F, 8'h00}};
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      bus(1'b1, IDX_TS0_CAPTURE, 8'hFF, 4'hF);
      bus(1'b1, 10'h070, 8'hFF, 4'hF);
      foreach (tbl[i])
         rd(IDX_MODE + 10'(i), (i == 1) ? STATUS_RST : 8'h00, 8'hFF);
      rd(10'h070, 8'h00, 8'hFF);
      $display("reset values done");
      st <= 5'h1D;
      @(posedge sys_clk);
      st <= 5'h00;
      repeat (2) @(posedge sys_clk);
      rd(IDX_STATUS, 8'h00, 8'hFF);
      rd(IDX_SYNC_EVENTS, 8'h1D, 8'hFF);
      bus(1'b1, IDX_SYNC_EVENTS, 8'h05, 4'hF);
      rd(IDX_SYNC_EVENTS, 8'h18, 8'hFF);
      bus(1'b1, IDX_SYNC_EVENTS, 8'h18, 4'hE);
      rd(IDX_SYNC_EVENTS, 8'h18, 8'hFF);
      bus(1'b1, IDX_SYNC_EVENTS, 8'h18, 4'hF);
      rd(IDX_SYNC_EVENTS, 8'h00, 8'hFF);
      $display("status change flags done");
      rx_align_moved <= 1'b1;
      @(posedge sys_clk);
      rx_align_moved <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({31'h0, frame_irq}, 32'h0);
      rd(IDX_ERR_EVENTS, 8'h01, 8'h03);
      bus(1'b1, IDX_IRQ_EN, 8'h01, 4'hF);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, frame_irq}, 32'h1);
      bus(1'b1, IDX_ERR_EVENTS, 8'h01, 4'hF);
      chk({31'h0, frame_irq}, 32'h0);
      rx_align_moved <= 1'b1;
      @(posedge sys_clk);
      rx_align_moved <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, frame_irq}, 32'h1);
      bus(1'b1, IDX_IRQ_EN, 8'h02, 4'hF);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, frame_irq}, 32'h0);
      inj <= 5'h01;
      repeat (600) @(posedge sys_clk);
      inj <= 5'h00;
      chk({31'h0, frame_irq}, 32'h1);
      bus(1'b1, IDX_ERR_EVENTS, 8'h03, 4'hF);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, frame_irq}, 32'h0);
      bus(1'b1, IDX_IRQ_EN, 8'h00, 4'hF);
      $display("interrupt done");
      // Each case: mode, status, injected faults, then the error flags after quiet time
      foreach (tbl[i]) begin
         md = tbl[i].mode;
         bus(1'b1, IDX_MODE, tbl[i].mode, 4'hF);
         st <= tbl[i].st;
         bus(1'b1, IDX_ERR_EVENTS, 8'hFF, 4'hF);
         bus(1'b1, IDX_ERR_COUNT, 8'h00, 4'hF);
         n = nfe;
         // Faults switch outside the overhead slot so no frame sees half a fault
         while (rx_timeslot == TS_OVERHEAD)
            @(posedge sys_clk);
         inj <= tbl[i].inj;
         repeat (4200) @(posedge sys_clk);
         while (rx_timeslot == TS_OVERHEAD)
            @(posedge sys_clk);
         inj <= 5'h00;
         repeat (2200) @(posedge sys_clk);
         rd(IDX_ERR_EVENTS, tbl[i].e, 8'hFF);
         rd(IDX_ERR_COUNT, 8'(nfe - n), 8'hFF);
      end
      // Far fewer than 915 errors fit in the short window, so the flag must stay clear
      rd(IDX_SYNC_EVENTS, 8'h00, 8'h20);
      $display("error events done");
      o = ovh;
      st <= 5'h00;
      for (k = 0; k < 2; k++) begin
         repeat (8400) @(posedge sys_clk);
         n = 0;
         while (!(rx_crc_frame == 4'h0 && rx_timeslot == 5'd2) && n < 5000) begin
            @(posedge sys_clk);
            n++;
         end
         if (n >= 5000)
            failures++;
         rd(IDX_TS0_CAPTURE, {o[7], 1'b0, o[5:0]}, 8'hBF);
         rd(IDX_TS16_SPARE, {5'h00, o[2:0]}, 8'hFF);
         st <= 5'h0D;
         ovh <= ~o;
      end
      $display("overhead capture done");
      stop_test();
   end
endmodule
bind e1_rx_framer_event_report e1_rx_checker chk (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_bit_valid, .rx_timeslot,
   .rx_bit_index, .rx_align_moved, .frame_irq);
